/* File: common/vlm_map.svh */
// offsets, field positions, reset values and limits of the velocity limit monitor
`ifndef VLM_MAP_SVH
`define VLM_MAP_SVH
`define VLM_IDX_CH1        16'h2021
`define VLM_IDX_CH4        16'h2024
`define VLM_IDX_STATUS     16'h2026
`define VLM_IDX_IO1        16'h2050
`define VLM_IDX_IO2        16'h2051
`define VLM_IDX_GENERAL    16'h2000
`define VLM_SUB_CTRL       8'h01
`define VLM_SUB_LIMIT      8'h02
`define VLM_SUB_HYST       8'h03
`define VLM_SUB_START      8'h04
`define VLM_SUB_END        8'h05
`define VLM_SUB_UNIT       8'h02
`define VLM_SUB_DIR        8'h04
`define VLM_CTRL_MODE_BIT  0
`define VLM_CTRL_DIR_BIT   1
`define VLM_CTRL_EN_BIT    2
`define VLM_CTRL_MASK      8'h07
`define VLM_STAT_CH_LSB    3
`define VLM_STAT_DYN_BIT   7
`define VLM_STAT_ACT_LSB   8
`define VLM_STAT_DACT_BIT  12
`define VLM_IO_DIR_BIT     0
`define VLM_IO_POL_BIT     1
`define VLM_IO_SPEED_BIT   10
`define VLM_RST_CTRL       8'h00
`define VLM_RST_LIMIT      16'h0000
`define VLM_RST_HYST       16'h0064
`define VLM_RST_POS        32'h00000000
`define VLM_RST_IO         32'h00000000
`define VLM_SPEED_MAX      16'h4E20
`define VLM_POS_MAX        32'h000F423F
`define VLM_POS_MIN        32'hFFF0BDC1
`endif

/* File: common/vlm_pkg.sv */
// types shared by the velocity limit monitor files
package vlm_pkg;
  typedef logic [7:0]         vlm_ctrl_type;
  typedef logic [15:0]        vlm_speed_type;
  typedef logic signed [31:0] vlm_pos_type;
  typedef logic [1:0]         vlm_chan_type;
  typedef enum logic [1:0] {
    VLM_WR_IDLE,
    VLM_WR_APPLY,
    VLM_WR_ERROR
  } vlm_wr_state_type;
endpackage

/* File: rtl/vlm_channel.sv */
// one velocity monitor channel: window, direction and hysteresis check
`timescale 1ns/10ps
`include "vlm_map.svh"
module vlm_channel (
  input  wire logic                 clock,        // measurement cycle clock
  input  wire logic                 reset_n,      // async reset, active low
  input  wire vlm_pkg::vlm_ctrl_type ctrl,        // check-control byte
  input  wire vlm_pkg::vlm_speed_type limit,      // limit magnitude
  input  wire vlm_pkg::vlm_speed_type hyst,       // hysteresis magnitude
  input  wire vlm_pkg::vlm_pos_type start_pos,    // window start
  input  wire vlm_pkg::vlm_pos_type end_pos,      // window end
  input  wire vlm_pkg::vlm_pos_type position,     // current position
  input  wire vlm_pkg::vlm_pos_type velocity,     // signed velocity
  output logic                      violated,     // flag, registered
  output logic                      active        // comparison active
);
  import vlm_pkg::*;
  logic        violated_reg;
  logic        violated_next;
  logic        active_reg;
  logic        active_next;
  logic [31:0] speed_abs;
  logic [31:0] upper;
  logic [31:0] lower;
  logic        in_window;
  logic        dir_ok;
  logic        ascending;

  always_comb begin
    speed_abs = velocity[31] ? 32'(-velocity) : 32'(velocity);
    ascending = end_pos > start_pos;
    in_window = ascending ? (position >= start_pos && position <= end_pos)
                          : (position >= end_pos && position <= start_pos);
    // direction by velocity sign, which already follows count direction
    dir_ok = !ctrl[`VLM_CTRL_DIR_BIT] ||
             (ascending ? !velocity[31] && velocity != 0 : velocity[31]);
    active_next = ctrl[`VLM_CTRL_EN_BIT] && (start_pos != end_pos) &&
                  in_window && dir_ok;
    upper = 32'(limit) + 32'(hyst);
    lower = (hyst > limit) ? 32'h00000000 : 32'(limit - hyst);
    violated_next = violated_reg;
    if (!active_next) begin
      violated_next = 1'b0;
    end else if (!ctrl[`VLM_CTRL_MODE_BIT]) begin
      if (speed_abs > 32'(limit)) violated_next = 1'b1;
      else if (speed_abs <= lower) violated_next = 1'b0;
    end else begin
      if (speed_abs < 32'(limit)) violated_next = 1'b1;
      else if (speed_abs >= upper) violated_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      violated_reg <= 1'b0;
      active_reg   <= 1'b0;
    end else begin
      violated_reg <= violated_next;
      active_reg   <= active_next;
    end
  end

  assign violated = violated_reg;
  assign active   = active_reg;

  a_inactive_clear: assert property (@(posedge clock) disable iff (!reset_n)
    !active_next |=> !violated_reg) else $error("flag set while inactive");
  a_equal_window: assert property (@(posedge clock) disable iff (!reset_n)
    (start_pos == end_pos) |=> !violated_reg) else $error("flag with empty window");
endmodule // vlm_channel

/* File: rtl/vlm_monitor.sv */
// velocity limit monitor: object store, four channels, status word and outputs
`timescale 1ns/10ps
`include "vlm_map.svh"
module vlm_monitor (
  input  wire logic                  clock,        // measurement cycle clock
  input  wire logic                  reset_n,      // async reset, active low
  input  wire logic                  obj_wr,       // object write strobe
  input  wire logic [15:0]           obj_index,    // object index
  input  wire logic [7:0]            obj_sub,      // sub-index
  input  wire logic [31:0]           obj_wdata,    // write data
  input  wire logic [31:0]           io1_config,   // I/O 1 configuration word
  input  wire logic [31:0]           io2_config,   // I/O 2 configuration word
  input  wire logic                  unit_inch,    // general unit selection
  input  wire logic                  count_neg,    // negative count direction
  input  wire vlm_pkg::vlm_pos_type  raw_velocity, // velocity, mm/s positive away
  input  wire vlm_pkg::vlm_pos_type  raw_position, // position in selected unit
  input  wire logic                  dyn_violated, // dynamic channel flag
  input  wire logic                  dyn_active,   // dynamic channel comparing
  output logic                       obj_ack,      // write accepted, pulse
  output logic                       obj_err,      // write refused, pulse
  output logic [15:0]                speed_status, // velocity status word
  output logic                       io1_out,      // switching output 1 level
  output logic                       io2_out,      // switching output 2 level
  output vlm_pkg::vlm_pos_type       velocity_out  // reported velocity
);
  import vlm_pkg::*;

  vlm_ctrl_type     ctrl_reg   [4];
  vlm_ctrl_type     ctrl_next  [4];
  vlm_speed_type    limit_reg  [4];
  vlm_speed_type    limit_next [4];
  vlm_speed_type    hyst_reg   [4];
  vlm_speed_type    hyst_next  [4];
  vlm_pos_type      start_reg  [4];
  vlm_pos_type      start_next [4];
  vlm_pos_type      end_reg    [4];
  vlm_pos_type      end_next   [4];
  vlm_wr_state_type wr_state_reg;
  vlm_wr_state_type wr_state_next;
  logic             ack_reg;
  logic             ack_next;
  logic             err_reg;
  logic             err_next;
  logic [15:0]      status_reg;
  logic [15:0]      status_next;
  logic             io1_reg;
  logic             io1_next;
  logic             io2_reg;
  logic             io2_next;
  vlm_pos_type      vel_reg;
  vlm_pos_type      vel_next;
  vlm_pos_type      vel_signed;
  logic [3:0]       ch_violated;
  logic [3:0]       ch_active;
  logic             any_speed;
  logic             hit_chan;
  vlm_chan_type     chan;
  logic             val_ok;

  function automatic logic drive_out(input logic [31:0] cfg, input logic event_on);
    logic level;
    level = cfg[`VLM_IO_SPEED_BIT] && event_on;
    if (!cfg[`VLM_IO_DIR_BIT]) return 1'b0;
    return cfg[`VLM_IO_POL_BIT] ? level : !level;
  endfunction

  function automatic logic pos_in_range(input logic [31:0] v);
    return $signed(v) <= $signed(`VLM_POS_MAX) && $signed(v) >= $signed(`VLM_POS_MIN);
  endfunction

  // inch conversion: (in/100)/s = mm/s * 100 / 25.4, done as *3937/1000
  always_comb begin
    logic signed [47:0] scaled;
    scaled = 48'sd0;
    vel_signed = count_neg ? 32'(-raw_velocity) : raw_velocity;
    if (unit_inch) begin
      scaled = (48'(raw_velocity) * 48'sd3937) / 48'sd1000;
      vel_signed = count_neg ? 32'(-scaled) : 32'(scaled);
    end
    vel_next = vel_signed;
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_chan
      vlm_channel u_chan (
        .clock     (clock),
        .reset_n   (reset_n),
        .ctrl      (ctrl_reg[g] & `VLM_CTRL_MASK),
        .limit     (limit_reg[g]),
        .hyst      (hyst_reg[g]),
        .start_pos (start_reg[g]),
        .end_pos   (end_reg[g]),
        .position  (raw_position),
        .velocity  (vel_signed),
        .violated  (ch_violated[g]),
        .active    (ch_active[g])
      );
    end
  endgenerate

  // object write decode
  always_comb begin
    hit_chan = obj_index >= `VLM_IDX_CH1 && obj_index <= `VLM_IDX_CH4;
    chan     = vlm_chan_type'(obj_index - `VLM_IDX_CH1);
    case (obj_sub)
      `VLM_SUB_CTRL:  val_ok = obj_wdata <= 32'(`VLM_CTRL_MASK);
      `VLM_SUB_LIMIT,
      `VLM_SUB_HYST:  val_ok = obj_wdata <= 32'(`VLM_SPEED_MAX);
      `VLM_SUB_START,
      `VLM_SUB_END:   val_ok = pos_in_range(obj_wdata);
      default:        val_ok = 1'b0;
    endcase
    for (int i = 0; i < 4; i++) begin
      ctrl_next[i]  = ctrl_reg[i];
      limit_next[i] = limit_reg[i];
      hyst_next[i]  = hyst_reg[i];
      start_next[i] = start_reg[i];
      end_next[i]   = end_reg[i];
    end
    ack_next      = 1'b0;
    err_next      = 1'b0;
    wr_state_next = VLM_WR_IDLE;
    case (wr_state_reg)
      VLM_WR_IDLE,
      VLM_WR_APPLY,
      VLM_WR_ERROR: begin
        if (obj_wr && hit_chan && val_ok) begin
          wr_state_next = VLM_WR_APPLY;
          ack_next      = 1'b1;
          case (obj_sub)
            `VLM_SUB_CTRL:  ctrl_next[chan]  = obj_wdata[7:0];
            `VLM_SUB_LIMIT: limit_next[chan] = obj_wdata[15:0];
            `VLM_SUB_HYST:  hyst_next[chan]  = obj_wdata[15:0];
            `VLM_SUB_START: start_next[chan] = obj_wdata;
            default:        end_next[chan]   = obj_wdata;
          endcase
        end else if (obj_wr) begin
          wr_state_next = VLM_WR_ERROR;
          err_next      = 1'b1;
        end
      end
      default: wr_state_next = VLM_WR_IDLE;
    endcase
  end

  // status word and outputs
  always_comb begin
    any_speed   = |ch_violated || dyn_violated;
    status_next = 16'h0000;
    status_next[`VLM_STAT_CH_LSB +: 4]  = ch_violated;
    status_next[`VLM_STAT_DYN_BIT]      = dyn_violated;
    status_next[`VLM_STAT_ACT_LSB +: 4] = ch_active;
    status_next[`VLM_STAT_DACT_BIT]     = dyn_active;
    status_next[1] = vel_signed != 0;
    status_next[2] = vel_signed[31];
    io1_next = drive_out(io1_config, any_speed);
    io2_next = drive_out(io2_config, any_speed);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        ctrl_reg[i]  <= `VLM_RST_CTRL;
        limit_reg[i] <= `VLM_RST_LIMIT;
        hyst_reg[i]  <= `VLM_RST_HYST;
        start_reg[i] <= `VLM_RST_POS;
        end_reg[i]   <= `VLM_RST_POS;
      end
      wr_state_reg <= VLM_WR_IDLE;
      ack_reg      <= 1'b0;
      err_reg      <= 1'b0;
      status_reg   <= 16'h0000;
      io1_reg      <= 1'b0;
      io2_reg      <= 1'b0;
      vel_reg      <= `VLM_RST_POS;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ctrl_reg[i]  <= ctrl_next[i];
        limit_reg[i] <= limit_next[i];
        hyst_reg[i]  <= hyst_next[i];
        start_reg[i] <= start_next[i];
        end_reg[i]   <= end_next[i];
      end
      wr_state_reg <= wr_state_next;
      ack_reg      <= ack_next;
      err_reg      <= err_next;
      status_reg   <= status_next;
      io1_reg      <= io1_next;
      io2_reg      <= io2_next;
      vel_reg      <= vel_next;
    end
  end

  assign obj_ack      = ack_reg;
  assign obj_err      = err_reg;
  assign speed_status = status_reg;
  assign io1_out      = io1_reg;
  assign io2_out      = io2_reg;
  assign velocity_out = vel_reg;

  a_status_follow: assert property (@(posedge clock) disable iff (!reset_n)
    status_reg[`VLM_STAT_CH_LSB +: 4] == $past(ch_violated)) else $error("status lag");
  a_limit_range: assert property (@(posedge clock) disable iff (!reset_n)
    obj_wr && obj_sub == `VLM_SUB_LIMIT && obj_wdata > 32'(`VLM_SPEED_MAX)
    |=> obj_err && !obj_ack) else $error("over-range limit taken");
  a_hyst_store: assert property (@(posedge clock) disable iff (!reset_n)
    obj_wr && hit_chan && obj_sub == `VLM_SUB_HYST && val_ok
    |=> hyst_reg[$past(chan)] == $past(obj_wdata[15:0])) else $error("hyst lost");
  a_pos_range: assert property (@(posedge clock) disable iff (!reset_n)
    obj_wr && obj_sub == `VLM_SUB_START && !pos_in_range(obj_wdata)
    |=> obj_err) else $error("over-range position taken");
  a_output_high: assert property (@(posedge clock) disable iff (!reset_n)
    io1_config[0] && io1_config[1] && io1_config[10] && any_speed
    |=> io1_out) else $error("output 1 missing");
  a_disabled_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    !ctrl_reg[0][`VLM_CTRL_EN_BIT] ##1 !ctrl_reg[0][`VLM_CTRL_EN_BIT]
    |=> !status_reg[`VLM_STAT_CH_LSB]) else $error("disabled channel flags");
  c_overspeed: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(status_reg[`VLM_STAT_CH_LSB]));
  c_clear: cover property (@(posedge clock) disable iff (!reset_n)
    $fell(status_reg[`VLM_STAT_CH_LSB + 3]));
  c_io2: cover property (@(posedge clock) disable iff (!reset_n) $rose(io2_out));
  c_refuse: cover property (@(posedge clock) disable iff (!reset_n) obj_err);
endmodule // vlm_monitor

/* File: sim/vlm_master.sv */
// fieldbus master model that writes the monitor configuration objects
`timescale 1ns/10ps
module vlm_master (
  input  wire logic        clock,     // measurement clock
  input  wire logic        obj_ack,   // write accepted
  input  wire logic        obj_err,   // write refused
  output logic             obj_wr,    // write strobe
  output logic [15:0]      obj_index, // object index
  output logic [7:0]       obj_sub,   // sub-index
  output logic [31:0]      obj_wdata  // write data
);
  initial begin
    obj_wr = 1'b0;
    obj_index = 16'h0000;
    obj_sub = 8'h00;
    obj_wdata = 32'h00000000;
  end
  // one word per write; range kept by the caller except on refusal tests
  task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
                    output logic a, output logic e);
    @(negedge clock);
    obj_wr = 1'b1;
    obj_index = ix;
    obj_sub = sb;
    obj_wdata = d;
    @(negedge clock);
    a = obj_ack;
    e = obj_err;
    obj_wr = 1'b0;
    // released lines show no stale value
    obj_index = ~ix;
    obj_sub = ~sb;
    obj_wdata = ~d;
  endtask
endmodule // vlm_master

/* File: sim/velocity_limit_monitor_bench.sv */
// self-checking bench of the velocity limit monitor
`timescale 1ns/10ps
`include "vlm_map.svh"
module velocity_limit_monitor_bench;
  import vlm_pkg::*;
  logic        clock, reset_n, obj_wr, obj_ack, obj_err, unit_inch, count_neg;
  logic        dyn_violated, dyn_active, io1_out, io2_out;
  logic [15:0] obj_index, speed_status;
  logic [7:0]  obj_sub;
  logic [31:0] obj_wdata, io1_config, io2_config;
  vlm_pos_type raw_velocity, raw_position, velocity_out;
  int          fails, n_checks, cycles;
  vlm_master i_vlm_master (.clock(clock), .obj_ack(obj_ack), .obj_err(obj_err),
    .obj_wr(obj_wr), .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata));
  vlm_monitor i_vlm_monitor (.clock(clock), .reset_n(reset_n), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata),
    .io1_config(io1_config), .io2_config(io2_config), .unit_inch(unit_inch),
    .count_neg(count_neg), .raw_velocity(raw_velocity), .raw_position(raw_position),
    .dyn_violated(dyn_violated), .dyn_active(dyn_active), .obj_ack(obj_ack),
    .obj_err(obj_err), .speed_status(speed_status), .io1_out(io1_out),
    .io2_out(io2_out), .velocity_out(velocity_out));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one write with its expected answer
  task automatic wx(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
                    input logic e_exp);
    logic a, e;
    i_vlm_master.wr(ix, sb, d, a, e);
    chk("obj_ack", a, !e_exp);
    chk("obj_err", e, e_exp);
  endtask
  // hysteresis left at its reset value when h is all ones
  task automatic cfg(input int ch, input logic [7:0] c, input logic [15:0] l,
                     input logic [15:0] h, input logic [31:0] s, input logic [31:0] e);
    logic [15:0] ix;
    ix = `VLM_IDX_CH1 + 16'(ch);
    wx(ix, `VLM_SUB_LIMIT, {16'h0000, l}, 1'b0);
    if (h != 16'hFFFF) wx(ix, `VLM_SUB_HYST, {16'h0000, h}, 1'b0);
    wx(ix, `VLM_SUB_START, s, 1'b0);
    wx(ix, `VLM_SUB_END, e, 1'b0);
    wx(ix, `VLM_SUB_CTRL, {24'h000000, c}, 1'b0);
  endtask
  // flag lands two edges after the input; margin for the write path
  task automatic go(input logic [31:0] v);
    @(negedge clock);
    raw_velocity = v;
    repeat (4) @(negedge clock);
  endtask
  task automatic t_refuse();
    wx(16'h2025, `VLM_SUB_CTRL, 32'h00000004, 1'b1);
    wx(`VLM_IDX_CH1, 8'h06, 32'h00000000, 1'b1);
    wx(`VLM_IDX_CH1, `VLM_SUB_CTRL, 32'h00000008, 1'b1);
    wx(`VLM_IDX_CH1, `VLM_SUB_LIMIT, 32'h00004E21, 1'b1);
    wx(`VLM_IDX_CH1, `VLM_SUB_HYST, 32'h00004E21, 1'b1);
    wx(`VLM_IDX_CH1, `VLM_SUB_START, 32'h000F4240, 1'b1);
    wx(`VLM_IDX_CH1, `VLM_SUB_END, 32'hFFF0BDC0, 1'b1);
    wx(`VLM_IDX_CH4, `VLM_SUB_LIMIT, 32'h00004E20, 1'b0);
  endtask
  task automatic t_over();
    io1_config = 32'h00000403;
    io2_config = 32'h00000401;
    cfg(0, 8'h04, 16'h03E8, 16'hFFFF, 32'hFFFFFF9C, 32'h00000064);
    go(32'h000003E9);
    chk("ch1 flag", speed_status[3], 1'b1);
    chk("ch1 active", speed_status[8], 1'b1);
    chk("io1 high", io1_out, 1'b1);
    chk("io2 low", io2_out, 1'b0);
    go(32'h000003B6);
    chk("ch1 hold", speed_status[3], 1'b1);
    go(32'h00000384);
    chk("ch1 clear", speed_status[3], 1'b0);
    chk("io1 idle", io1_out, 1'b0);
    chk("io2 idle", io2_out, 1'b1);
    wx(`VLM_IDX_CH1, `VLM_SUB_CTRL, 32'h00000000, 1'b0);
    go(32'h00002710);
    chk("ch1 off", speed_status[3], 1'b0);
    chk("io1 off", io1_out, 1'b0);
    dyn_violated = 1'b1;
    dyn_active = 1'b1;
    go(32'h00000000);
    chk("io1 dyn", io1_out, 1'b1);
    chk("dyn status", {speed_status[12], speed_status[7]}, 2'b11);
    dyn_violated = 1'b0;
    dyn_active = 1'b0;
  endtask
  task automatic t_under();
    cfg(1, 8'h05, 16'h01F4, 16'h0032, 32'hFFFFFF9C, 32'h00000064);
    go(32'h00000190);
    chk("ch2 under", speed_status[4], 1'b1);
    go(32'h0000021C);
    chk("ch2 hold", speed_status[4], 1'b1);
    go(32'h00000226);
    chk("ch2 clear", speed_status[4], 1'b0);
    wx(`VLM_IDX_CH1 + 16'h0001, `VLM_SUB_CTRL, 32'h00000000, 1'b0);
  endtask
  task automatic t_dir();
    raw_position = 32'sd5200;
    cfg(2, 8'h06, 16'h0064, 16'h000A, 32'h0000157C, 32'h00001388);
    go(32'h000001F4);
    chk("ch3 wrong way", speed_status[5], 1'b0);
    go(32'hFFFFFE0C);
    chk("ch3 right way", speed_status[5], 1'b1);
    chk("velocity", velocity_out, 32'hFFFFFE0C);
    chk("moving negative", speed_status[2:1], 2'b11);
    count_neg = 1'b1;
    go(32'hFFFFFE0C);
    chk("ch3 inverted", speed_status[5], 1'b0);
    chk("velocity inv", velocity_out, 32'h000001F4);
    chk("moving positive", speed_status[2:1], 2'b01);
    count_neg = 1'b0;
    wx(`VLM_IDX_CH1 + 16'h0002, `VLM_SUB_CTRL, 32'h00000004, 1'b0);
    go(32'h000001F4);
    chk("ch3 indep", speed_status[5], 1'b1);
    wx(`VLM_IDX_CH1 + 16'h0002, `VLM_SUB_CTRL, 32'h00000000, 1'b0);
    raw_position = 32'sd0;
  endtask
  task automatic t_window();
    cfg(3, 8'h04, 16'h0000, 16'h0000, 32'h00000000, 32'h00000000);
    go(32'h00000064);
    chk("ch4 equal", speed_status[6], 1'b0);
    chk("ch4 inactive", speed_status[11], 1'b0);
    wx(`VLM_IDX_CH4, `VLM_SUB_END, 32'h0000000A, 1'b0);
    go(32'h00000064);
    chk("ch4 flag", speed_status[6], 1'b1);
    chk("ch4 active", speed_status[11], 1'b1);
    chk("others", speed_status[5:3], 3'b000);
    wx(`VLM_IDX_CH4, `VLM_SUB_CTRL, 32'h00000000, 1'b0);
  endtask
  task automatic t_unit();
    unit_inch = 1'b1;
    go(32'h000003E8);
    chk("velocity inch", velocity_out, 32'h00000F61);
    unit_inch = 1'b0;
  endtask
  initial begin
    {reset_n, unit_inch, count_neg, dyn_violated, dyn_active} = 5'b00000;
    {io1_config, io2_config} = 64'h0;
    raw_velocity = 32'sd0;
    raw_position = 32'sd0;
    fails = 0;
    n_checks = 0;
    cycles = 0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    chk("status reset", speed_status, 16'h0000);
    t_refuse();
    t_over();
    t_under();
    t_dir();
    t_window();
    t_unit();
    test_done();
  end
endmodule // velocity_limit_monitor_bench
